// ==== compass_cmd_pkg.sv ====
// Package: constants and carriers for the compass setup command decoder
package compass_cmd_pkg;
   localparam logic [7:0] ADDR_COMPASS = 8'he4;
   localparam logic [7:0] ADDR_INERTIAL = 8'he6;
   localparam logic [7:0] CAT_COMPASS = 8'h34;
   localparam logic [7:0] CAT_INERTIAL = 8'h35;
   localparam logic [7:0] LEN_SHORT = 8'h02;
   localparam logic [7:0] LEN_PARAM = 8'h03;
   localparam logic [7:0] FN_FACTORY = 8'h01;
   localparam logic [7:0] FN_DEV_ENTER = 8'h02;
   localparam logic [7:0] FN_DEV_END = 8'h03;
   localparam logic [7:0] FN_DEV_CANCEL = 8'h04;
   localparam logic [7:0] FN_DEV_STORE = 8'h05;
   localparam logic [7:0] FN_NORTH = 8'h06;
   localparam logic [7:0] FN_ZOFF_START = 8'h07;
   localparam logic [7:0] FN_ZOFF_END = 8'h08;
   localparam logic [7:0] FN_ZOFF_ABORT = 8'h09;
   localparam logic [7:0] FN_MODE = 8'h0a;
   localparam logic [7:0] FN_ZGAIN = 8'h0b;
   localparam logic [7:0] FN_RAW = 8'h0f;
   localparam logic [7:0] FN_INCL = 8'h12;
   localparam logic [1:0] MODE_2D = 2'h1;
   localparam logic [1:0] MODE_3D_TILT = 2'h2;
   localparam logic [1:0] MODE_GYRO = 2'h3;
   localparam logic [15:0] ZGAIN_NEUTRAL = 16'h03e8;
   localparam logic [1:0] MODE_RESET = 2'h2;
   // APB register byte addresses
   localparam logic [7:0] OFS_RXDATA = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ZGAIN = 8'h08;
   localparam logic [7:0] OFS_EVENTS = 8'h0c;
   localparam logic [7:0] OFS_CONTROL = 8'h10;
   // Deviation message period: 250 ms, about four per second
   localparam int DEV_PERIOD_MS = 250;
   localparam int CLK_HZ = 50000000;
   localparam int DEV_PERIOD_CYC = CLK_HZ / 1000 * DEV_PERIOD_MS;
   typedef enum {ST_ADDR, ST_LEN, ST_CAT, ST_FN, ST_PARAM} parse_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic factory_restore;
      logic dev_apply;
      logic dev_discard;
      logic factory_overwrite;
      logic north_align;
      logic zoff_store;
      logic zoff_abort;
      logic raw_request;
      logic incl_request;
      logic dev_message;
   } cmd_events_t;
endpackage

// ==== dev_msg_timer.sv ====
// Periodic tick generator for deviation data messages
module dev_msg_timer #(
   parameter int PERIOD = compass_cmd_pkg::DEV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control
   input wire logic run,
   output logic tick
);
   // Refused at elaboration: a shorter period cannot count a full cycle
   if (PERIOD < 2) begin : gen_period_check
      $error("PERIOD too small");
   end
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } timer_state_t;
   timer_state_t state_reg;
   timer_state_t state_next;
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (!run) begin
         // Restart so the first message comes one full period after entry
         state_next.count = 32'h0;
      end else if (state_reg.count == 32'(PERIOD - 1)) begin
         state_next.count = 32'h0;
         state_next.tick = 1'b1;
      end else begin
         state_next.count = state_reg.count + 32'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign tick = state_reg.tick;
endmodule

// ==== compass_setup_command_decoder.sv ====
// Compass setup command decoder with APB register access
// Contract
// - Compass command: compass address, length, category 52, function byte in order.
// - Length 2 for no parameter, length 3 with one parameter byte.
// - Inertial category 53 function 18 requests magnetic inclination transmission.
// - Function 1 restores factory compensation, discarding user deviation.
// - Function 2 enters deviation mode; deviation messages about four per second.
// - Function 3 leaves deviation mode and applies processed result.
// - Function 4 leaves deviation mode, discards data, keeps compensation.
// - Function 5 ends deviation mode, applies result, overwrites factory default.
// - Function 6 aligns north so heading reads zero, small correction.
// - Function 7 starts Z axis offset measurement session.
// - Function 8 ends Z offset session, computes and stores offset.
// - Function 9 aborts Z offset session, no setup change.
// - Function 10 mode byte: 1 two axis, 2 tilt, 3 gyro slaved.
// - Function 11 adds signed byte to Z gain, neutral 1000.
// - Function 15 requests raw data of three magnetometers.
// - Inertial commands: inertial address, length, category 53, function.
module compass_setup_command_decoder #(
   // Deviation message period in clock cycles
   parameter int DEV_PERIOD = compass_cmd_pkg::DEV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Command byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   // Decoded actions
   output compass_cmd_pkg::cmd_events_t events,
   output logic dev_mode,
   output logic zoff_mode,
   output logic [1:0] compass_mode,
   output logic [15:0] zgain
);
   typedef struct packed {
      compass_cmd_pkg::parse_state_t ps;
      logic is_inertial;
      logic [7:0] len;
      logic [7:0] fn;
      logic dev_mode;
      logic zoff_mode;
      logic [1:0] mode;
      logic [15:0] zgain;
      compass_cmd_pkg::cmd_events_t ev;
      logic [9:0] ev_sticky;
      logic [31:0] prdata;
      logic [7:0] bad_count;
   } dec_state_t;
   dec_state_t state_reg;
   dec_state_t state_next;
   logic dev_tick;
   logic apb_wr;
   logic apb_rd;
   logic sw_valid;
   logic [7:0] sw_byte;
   logic byte_valid;
   logic [7:0] byte_in;
   logic fn_done;
   logic [7:0] fn_now;
   logic [7:0] param_now;
   logic cmd_ok;

   function automatic logic needs_param(input logic [7:0] fn);
      return (fn == compass_cmd_pkg::FN_MODE) || (fn == compass_cmd_pkg::FN_ZGAIN) ||
             (fn == compass_cmd_pkg::FN_RAW);
   endfunction

   // Timer needs at least two cycles per period
   if (DEV_PERIOD < 2) begin : gen_period_check
      $error("DEV_PERIOD too small");
   end

   dev_msg_timer #(
      .PERIOD(DEV_PERIOD)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .run(state_reg.dev_mode),
      .tick(dev_tick)
   );

   // APB: zero wait states
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !(paddr == compass_cmd_pkg::OFS_RXDATA ||
      paddr == compass_cmd_pkg::OFS_STATUS || paddr == compass_cmd_pkg::OFS_ZGAIN ||
      paddr == compass_cmd_pkg::OFS_EVENTS || paddr == compass_cmd_pkg::OFS_CONTROL);
   assign sw_valid = apb_wr && paddr == compass_cmd_pkg::OFS_RXDATA;
   assign sw_byte = pwdata[7:0];
   // Serial link has priority; a software byte in the same cycle is dropped
   assign byte_valid = rx_valid || sw_valid;
   assign byte_in = rx_valid ? rx_byte : sw_byte;

   always_comb begin
      state_next = state_reg;
      state_next.ev = '0;
      fn_done = 1'b0;
      fn_now = state_reg.fn;
      param_now = 8'h00;
      cmd_ok = 1'b0;
      if (byte_valid) begin
         unique case (state_reg.ps)
            compass_cmd_pkg::ST_ADDR: begin
               if (byte_in == compass_cmd_pkg::ADDR_COMPASS) begin
                  state_next.ps = compass_cmd_pkg::ST_LEN;
                  state_next.is_inertial = 1'b0;
               end else if (byte_in == compass_cmd_pkg::ADDR_INERTIAL) begin
                  state_next.ps = compass_cmd_pkg::ST_LEN;
                  state_next.is_inertial = 1'b1;
               end
            end
            compass_cmd_pkg::ST_LEN: begin
               state_next.len = byte_in;
               state_next.ps = compass_cmd_pkg::ST_CAT;
            end
            compass_cmd_pkg::ST_CAT: begin
               // Wrong category resyncs on the next address byte
               if ((!state_reg.is_inertial && byte_in == compass_cmd_pkg::CAT_COMPASS) ||
                   (state_reg.is_inertial && byte_in == compass_cmd_pkg::CAT_INERTIAL)) begin
                  state_next.ps = compass_cmd_pkg::ST_FN;
               end else begin
                  state_next.ps = compass_cmd_pkg::ST_ADDR;
                  state_next.bad_count = state_reg.bad_count + 8'h01;
               end
            end
            compass_cmd_pkg::ST_FN: begin
               state_next.fn = byte_in;
               fn_now = byte_in;
               if (!state_reg.is_inertial && needs_param(byte_in)) begin
                  state_next.ps = compass_cmd_pkg::ST_PARAM;
               end else begin
                  state_next.ps = compass_cmd_pkg::ST_ADDR;
                  fn_done = 1'b1;
               end
            end
            compass_cmd_pkg::ST_PARAM: begin
               param_now = byte_in;
               fn_done = 1'b1;
               state_next.ps = compass_cmd_pkg::ST_ADDR;
            end
         endcase
      end
      if (fn_done) begin
         // Length must match parameter count
         cmd_ok = state_reg.len == ((!state_reg.is_inertial && needs_param(fn_now)) ?
                  compass_cmd_pkg::LEN_PARAM : compass_cmd_pkg::LEN_SHORT);
         if (!cmd_ok) begin
            state_next.bad_count = state_reg.bad_count + 8'h01;
         end
      end
      if (cmd_ok && state_reg.is_inertial) begin
         if (fn_now == compass_cmd_pkg::FN_INCL) begin
            state_next.ev.incl_request = 1'b1;
         end
      end else if (cmd_ok) begin
         unique case (fn_now)
            compass_cmd_pkg::FN_FACTORY: begin
               state_next.ev.factory_restore = 1'b1;
               state_next.dev_mode = 1'b0;
            end
            compass_cmd_pkg::FN_DEV_ENTER: state_next.dev_mode = 1'b1;
            compass_cmd_pkg::FN_DEV_END: begin
               if (state_reg.dev_mode) begin
                  state_next.dev_mode = 1'b0;
                  state_next.ev.dev_apply = 1'b1;
               end
            end
            compass_cmd_pkg::FN_DEV_CANCEL: begin
               if (state_reg.dev_mode) begin
                  state_next.dev_mode = 1'b0;
                  state_next.ev.dev_discard = 1'b1;
               end
            end
            compass_cmd_pkg::FN_DEV_STORE: begin
               if (state_reg.dev_mode) begin
                  state_next.dev_mode = 1'b0;
                  state_next.ev.dev_apply = 1'b1;
                  state_next.ev.factory_overwrite = 1'b1;
               end
            end
            compass_cmd_pkg::FN_NORTH: state_next.ev.north_align = 1'b1;
            compass_cmd_pkg::FN_ZOFF_START: state_next.zoff_mode = 1'b1;
            compass_cmd_pkg::FN_ZOFF_END: begin
               if (state_reg.zoff_mode) begin
                  state_next.zoff_mode = 1'b0;
                  state_next.ev.zoff_store = 1'b1;
               end
            end
            compass_cmd_pkg::FN_ZOFF_ABORT: begin
               if (state_reg.zoff_mode) begin
                  state_next.zoff_mode = 1'b0;
                  state_next.ev.zoff_abort = 1'b1;
               end
            end
            compass_cmd_pkg::FN_MODE: begin
               // Mode 0 and values above 3 are ignored
               if (param_now >= 8'h01 && param_now <= 8'h03) begin
                  state_next.mode = param_now[1:0];
               end
            end
            compass_cmd_pkg::FN_ZGAIN: begin
               state_next.zgain = state_reg.zgain + {{8{param_now[7]}}, param_now};
            end
            compass_cmd_pkg::FN_RAW: state_next.ev.raw_request = 1'b1;
            default: begin
            end
         endcase
      end
      state_next.ev.dev_message = dev_tick && state_reg.dev_mode;
      // Sticky event log: set wins over software clear
      if (apb_wr && paddr == compass_cmd_pkg::OFS_EVENTS) begin
         state_next.ev_sticky = state_reg.ev_sticky & ~pwdata[9:0];
      end
      state_next.ev_sticky = state_next.ev_sticky | state_next.ev;
      if (apb_wr && paddr == compass_cmd_pkg::OFS_ZGAIN) begin
         state_next.zgain = pwdata[15:0];
      end
      if (apb_wr && paddr == compass_cmd_pkg::OFS_CONTROL && pwdata[0]) begin
         state_next.ps = compass_cmd_pkg::ST_ADDR;
         state_next.bad_count = 8'h00;
      end
      if (apb_rd) begin
         unique case (paddr)
            compass_cmd_pkg::OFS_STATUS: state_next.prdata = {16'h0, state_reg.bad_count, 4'h0,
               state_reg.mode, state_reg.zoff_mode, state_reg.dev_mode};
            compass_cmd_pkg::OFS_ZGAIN: state_next.prdata = {16'h0, state_reg.zgain};
            compass_cmd_pkg::OFS_EVENTS: state_next.prdata = {22'h0, state_reg.ev_sticky};
            default: state_next.prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '{ps: compass_cmd_pkg::ST_ADDR, is_inertial: 1'b0, len: 8'h00, fn: 8'h00,
            dev_mode: 1'b0, zoff_mode: 1'b0, mode: compass_cmd_pkg::MODE_RESET,
            zgain: compass_cmd_pkg::ZGAIN_NEUTRAL, ev: '0, ev_sticky: 10'h0,
            prdata: 32'h0, bad_count: 8'h00};
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.prdata;
   assign events = state_reg.ev;
   assign dev_mode = state_reg.dev_mode;
   assign zoff_mode = state_reg.zoff_mode;
   assign compass_mode = state_reg.mode;
   assign zgain = state_reg.zgain;

   chk_dev_end_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.dev_apply |-> !dev_mode && $past(dev_mode)) else $error("apply without session");
   chk_dev_cancel_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.dev_discard |-> !dev_mode && !events.dev_apply) else $error("bad cancel");
   chk_store_pairs: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.factory_overwrite |-> events.dev_apply) else $error("overwrite without apply");
   chk_zoff_store_sess: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.zoff_store |-> $past(zoff_mode) && !zoff_mode) else $error("zoff store idle");
   chk_zoff_abort_sess: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.zoff_abort |-> $past(zoff_mode) && !zoff_mode) else $error("zoff abort idle");
   chk_mode_legal: assert property (@(posedge clk_sys) disable iff (!rst_b)
      compass_mode != 2'h0) else $error("illegal compass mode");
   chk_dev_msg_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.dev_message |-> $past(dev_mode)) else $error("dev message outside mode");
   chk_gain_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !$past(apb_wr && paddr == compass_cmd_pkg::OFS_ZGAIN) && zgain != $past(zgain) |->
      $past(fn_done && cmd_ok && !state_reg.is_inertial && fn_now == compass_cmd_pkg::FN_ZGAIN))
      else $error("gain changed without command");
   chk_incl_inertial: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.incl_request |-> $past(state_reg.is_inertial)) else $error("incl from compass");
   chk_factory_ends_dev: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.factory_restore |-> !dev_mode)
      else $error("factory restore left session open");
   chk_dev_enter: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(fn_done && cmd_ok && !state_reg.is_inertial && fn_now == compass_cmd_pkg::FN_DEV_ENTER)
      |-> dev_mode)
      else $error("deviation session not entered");
   chk_zoff_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(fn_done && cmd_ok && !state_reg.is_inertial && fn_now == compass_cmd_pkg::FN_ZOFF_START)
      |-> zoff_mode)
      else $error("zoff session not entered");
   chk_bad_len_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(fn_done && !cmd_ok) |-> events[9:1] == 9'h0)
      else $error("event from bad length");
   chk_raw_after_param: assert property (@(posedge clk_sys) disable iff (!rst_b)
      events.raw_request |-> $past(state_reg.ps == compass_cmd_pkg::ST_PARAM))
      else $error("raw request before parameter");
   chk_mode_via_cmd: assert property (@(posedge clk_sys) disable iff (!rst_b)
      compass_mode != $past(compass_mode) |->
      $past(fn_done && cmd_ok && !state_reg.is_inertial && fn_now == compass_cmd_pkg::FN_MODE))
      else $error("mode changed without command");
   // Only a running session may produce an apply
   chk_idle_end_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(fn_done && cmd_ok && !state_reg.is_inertial && !state_reg.dev_mode &&
      (fn_now == compass_cmd_pkg::FN_DEV_END || fn_now == compass_cmd_pkg::FN_DEV_STORE))
      |-> !events.dev_apply)
      else $error("apply from idle end");
   cov_dev_session: cover property (@(posedge clk_sys) disable iff (!rst_b) events.dev_apply);
   cov_zoff_session: cover property (@(posedge clk_sys) disable iff (!rst_b) events.zoff_store);
   cov_gain_trim: cover property (@(posedge clk_sys) disable iff (!rst_b) zgain != $past(zgain));
   cov_incl: cover property (@(posedge clk_sys) disable iff (!rst_b) events.incl_request);
   cov_dev_message: cover property (@(posedge clk_sys) disable iff (!rst_b) events.dev_message);
endmodule

// ==== host_cmd_sender.sv ====
// Host instrument model: sends setup command frames as a byte stream
module host_cmd_sender (
   // Clock
   input wire logic clk_sys,
   // Byte stream toward the decoder
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'ha5;
   end

   // Bytes go out in frame order; a stale byte is inverted so it never looks valid
   task automatic send(input logic [7:0] frame[$], input int gap);
      foreach (frame[i]) begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_byte <= frame[i];
         repeat (gap) begin
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_byte <= ~frame[i];
         end
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
endmodule

// ==== test_compass_setup_command_decoder.sv ====
// Testbench for the compass setup command decoder
module test_compass_setup_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_valid;
   logic [7:0] rx_byte;
   compass_cmd_pkg::cmd_events_t events;
   logic dev_mode;
   logic zoff_mode;
   logic [1:0] compass_mode;
   logic [15:0] zgain;
   logic [9:0] ev_acc = 10'h0;
   logic ev_clr = 1'b0;
   logic [31:0] rd;
   logic err;
   // Short message period so a session shows several ticks
   localparam int MSG_PERIOD = 40;
   int n_msg = 0;
   int gap = 0;
   int cyc = 0;
   int error_cnt = 0;
   int n_checks = 0;

   always #10 clk_sys = ~clk_sys;

   compass_setup_command_decoder #(.DEV_PERIOD(MSG_PERIOD)) compass_setup_command_decoder_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .events(events), .dev_mode(dev_mode),
      .zoff_mode(zoff_mode), .compass_mode(compass_mode), .zgain(zgain));

   host_cmd_sender host_cmd_sender_inst (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte));

   // Collect every pulse from the clear at the start of a command to its check, so stray events within that window are caught too
   always @(posedge clk_sys) begin
      if (ev_clr) begin
         ev_acc <= 10'h0;
         n_msg <= 0;
      end else begin
         ev_acc <= ev_acc | events;
         n_msg <= n_msg + int'(events.dev_message);
      end
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_ev(input logic [9:0] exp, input logic [9:0] mask);
      n_checks++;
      if ((ev_acc & mask) !== exp) begin
         error_cnt++;
         $display("Error at %0t: events %h, expected %h", $time, ev_acc, exp);
      end
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cmd(input logic [7:0] f[$], input logic [9:0] exp, input logic [9:0] mask);
      @(posedge clk_sys);
      ev_clr <= 1'b1;
      @(posedge clk_sys);
      ev_clr <= 1'b0;
      host_cmd_sender_inst.send(f, gap);
      repeat (3) @(posedge clk_sys);
      #1;
      cmp_ev(exp, mask);
   endtask

   task automatic cs(input logic [7:0] fn, input logic [9:0] exp);
      cmd('{8'he4, 8'h02, 8'h34, fn}, exp, 10'h3ff);
   endtask

   task automatic t_reset();
      cmp({dev_mode, zoff_mode, compass_mode, zgain}, 32'h000203e8);
      apb(1'b0, compass_cmd_pkg::OFS_STATUS, 32'h0);
      cmp(rd, 32'h00000008);
      apb(1'b0, compass_cmd_pkg::OFS_ZGAIN, 32'h0);
      cmp(rd, 32'h000003e8);
   endtask

   task automatic t_dev();
      cs(8'h03, 10'h000);
      cs(8'h02, 10'h000);
      cmp({31'h0, dev_mode}, 32'h1);
      cs(8'h03, 10'h100);
      cmp({31'h0, dev_mode}, 32'h0);
      cs(8'h02, 10'h000);
      cs(8'h04, 10'h080);
      cmp({31'h0, dev_mode}, 32'h0);
      cs(8'h04, 10'h000);
      cs(8'h02, 10'h000);
      cmd('{8'he4, 8'h02, 8'h34, 8'h05}, 10'h140, 10'h3ff);
      cmp({31'h0, dev_mode}, 32'h0);
      cs(8'h01, 10'h200);
   endtask

   // Four periods of an open session hold exactly four messages
   task automatic t_msg();
      cs(8'h02, 10'h000);
      @(posedge clk_sys);
      ev_clr <= 1'b1;
      @(posedge clk_sys);
      ev_clr <= 1'b0;
      repeat (4 * MSG_PERIOD) @(posedge clk_sys);
      #1;
      cmp(n_msg, 32'h4);
      cs(8'h04, 10'h080);
      repeat (2 * MSG_PERIOD) @(posedge clk_sys);
      #1;
      cmp(n_msg, 32'h0);
   endtask

   task automatic t_apb();
      apb(1'b1, compass_cmd_pkg::OFS_ZGAIN, 32'h000003e8);
      #1;
      cmp({16'h0, zgain}, 32'h000003e8);
      apb(1'b1, compass_cmd_pkg::OFS_EVENTS, 32'h000003ff);
      apb(1'b0, compass_cmd_pkg::OFS_EVENTS, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, compass_cmd_pkg::OFS_RXDATA, 32'h000000e4);
      apb(1'b1, compass_cmd_pkg::OFS_RXDATA, 32'h00000002);
      apb(1'b1, compass_cmd_pkg::OFS_RXDATA, 32'h00000034);
      apb(1'b1, compass_cmd_pkg::OFS_RXDATA, 32'h00000006);
      apb(1'b0, compass_cmd_pkg::OFS_EVENTS, 32'h0);
      cmp(rd, 32'h00000020);
   endtask

   task automatic t_zoff();
      cs(8'h09, 10'h000);
      cs(8'h07, 10'h000);
      cmp({31'h0, zoff_mode}, 32'h1);
      cs(8'h08, 10'h010);
      cmp({31'h0, zoff_mode}, 32'h0);
      cs(8'h07, 10'h000);
      cs(8'h09, 10'h008);
      cmp({31'h0, zoff_mode}, 32'h0);
   endtask

   task automatic t_misc();
      cs(8'h06, 10'h020);
      cs(8'h0e, 10'h000);
      gap = 2;
      cmd('{8'he4, 8'h03, 8'h34, 8'h0f, 8'h00}, 10'h004, 10'h3ff);
      gap = 0;
      cmd('{8'he6, 8'h02, 8'h35, 8'h12}, 10'h002, 10'h3ff);
      cmd('{8'he6, 8'h02, 8'h35, 8'h01}, 10'h000, 10'h3ff);
   endtask

   task automatic t_mode();
      logic [1:0] m[3];
      m = '{2'h1, 2'h3, 2'h2};
      foreach (m[i]) begin
         cmd('{8'he4, 8'h03, 8'h34, 8'h0a, {6'h0, m[i]}}, 10'h000, 10'h3ff);
         cmp({30'h0, compass_mode}, {30'h0, m[i]});
      end
      cmd('{8'he4, 8'h03, 8'h34, 8'h0a, 8'h00}, 10'h000, 10'h3ff);
      cmp({30'h0, compass_mode}, 32'h2);
      cmd('{8'he4, 8'h02, 8'h34, 8'h0a, 8'h01}, 10'h000, 10'h3ff);
      cmp({30'h0, compass_mode}, 32'h2);
      cmd('{8'he4, 8'h02, 8'h35, 8'h01}, 10'h000, 10'h3ff);
      apb(1'b0, compass_cmd_pkg::OFS_STATUS, 32'h0);
      cmp(rd, 32'h00000208);
   endtask

   task automatic t_zgain();
      cmd('{8'he4, 8'h03, 8'h34, 8'h0b, 8'h0a}, 10'h000, 10'h3ff);
      cmp({16'h0, zgain}, 32'h000003f2);
      cmd('{8'he4, 8'h03, 8'h34, 8'h0b, 8'hff}, 10'h000, 10'h3ff);
      cmp({16'h0, zgain}, 32'h000003f1);
      cmd('{8'he4, 8'h03, 8'h34, 8'h0b, 8'h80}, 10'h000, 10'h3ff);
      apb(1'b0, compass_cmd_pkg::OFS_ZGAIN, 32'h0);
      cmp(rd, 32'h00000371);
      apb(1'b0, 8'h14, 32'h0);
      cmp({err, rd[30:0]}, 32'h80000000);
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_dev();
      t_msg();
      t_zoff();
      t_misc();
      t_mode();
      t_zgain();
      t_apb();
      summarize();
   end
endmodule
